/* File: common/dmrr_link_if.sv */
/*
 Interface joining the memory end and the controller end: command, bank, address halves,
 mirror select and active-low reset. Assumes both ends share clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface dmrr_link_if;
    import dmrr_pkg::*;
    logic [2:0]       cmd;
    dmrr_bank_t       bank;
    dmrr_addr_t       addr;
    logic             pin_mirror_select;
    logic             rst_n;
    modport mem  (input cmd, input bank, input addr, input pin_mirror_select, input rst_n);
    modport ctrl (output cmd, output bank, output addr, output pin_mirror_select, output rst_n);
endinterface
`default_nettype wire

/* File: common/dmrr_pkg.sv */
/*
 Package for the multiplexed-address refresh and reset link: commands, timing counts,
 pin layout widths and reset values shared by the memory end and the controller end.
 Assumes a single 10 MHz clock common to both ends.
*/
package dmrr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned RST_LOW_NS    = 100;
    localparam int unsigned RST_LOW_CYC   = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_NOP_CYC   = 100;
    localparam int unsigned INIT_LOW_CYC  = 10000;
    localparam int unsigned MRSC_CYC      = 4;
    localparam int unsigned ADDR_W        = 10;
    localparam int unsigned BANK_W        = 4;
    localparam int unsigned BANKS         = 16;
    localparam int unsigned REFCNT_W      = 16;
    localparam int unsigned MUX_BIT       = 9;
    localparam int unsigned CNT_W         = 16;

    typedef logic [ADDR_W-1:0] dmrr_addr_t;
    typedef logic [BANK_W-1:0] dmrr_bank_t;

    typedef enum logic [2:0] {
        DMRR_CMD_NOP  = 3'h0,
        DMRR_CMD_REFB = 3'h1,
        DMRR_CMD_REFA = 3'h2,
        DMRR_CMD_MRS  = 3'h3,
        DMRR_CMD_RD   = 3'h4,
        DMRR_CMD_WR   = 3'h5
    } dmrr_cmd_e;

    localparam dmrr_addr_t ADDR_RST = 10'h000;
    localparam dmrr_bank_t BANK_RST = 4'h0;
endpackage

/* File: design/dmrr_ctrl.sv */
/*
 Controller end: reset sequencing, init hold, mode write into multiplexed mode, command
 issue with all-bank refresh spacing. Assumes user requests held until accepted.
*/
`timescale 1ns/10ps
`default_nettype none
module dmrr_ctrl
    import dmrr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    dmrr_link_if.ctrl        link,
    input  wire logic        mirror_req,
    input  wire logic        reset_req,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_in,
    input  wire dmrr_bank_t  bank_in,
    input  wire dmrr_addr_t  addr_in,
    input  wire dmrr_addr_t  addr2_in,
    output logic             cmd_ready,
    output logic             init_done
);
    import dmrr_pkg::*;

    typedef enum logic [2:0] {
        DMRR_S_RST  = 3'h0,
        DMRR_S_NOP  = 3'h1,
        DMRR_S_HOLD = 3'h2,
        DMRR_S_MRS  = 3'h3,
        DMRR_S_WAIT = 3'h4,
        DMRR_S_RUN  = 3'h5,
        DMRR_S_H2   = 3'h6,
        DMRR_S_GAP  = 3'h7
    } dmrr_st_e;

    dmrr_st_e         st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0]       pc_q;
    dmrr_addr_t       a2_q;
    dmrr_bank_t       b2_q;
    logic             rq1_q;
    logic             rq2_q;

    // Mirrored layout is a bit reversal of the address and bank pin groups, not the command field; the memory end undoes it
    function automatic dmrr_addr_t rev_a(input dmrr_addr_t v, input logic m);
        dmrr_addr_t r;
        r = v;
        if (m) begin
            for (int i = 0; i < ADDR_W; i++) begin
                r[i] = v[ADDR_W-1-i];
            end
        end
        return r;
    endfunction

    function automatic dmrr_bank_t rev_b(input dmrr_bank_t v, input logic m);
        dmrr_bank_t r;
        r = v;
        if (m) begin
            for (int i = 0; i < BANK_W; i++) begin
                r[i] = v[BANK_W-1-i];
            end
        end
        return r;
    endfunction

    wire logic take = st_q == DMRR_S_RUN && cmd_valid && cmd_ready;
    wire logic two  = cmd_in == DMRR_CMD_REFA || cmd_in == DMRR_CMD_RD || cmd_in == DMRR_CMD_WR;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rq1_q <= 1'b0;
            rq2_q <= 1'b0;
        end else begin
            rq1_q <= reset_req;
            rq2_q <= rq1_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q                   <= DMRR_S_RST;
            cnt_q                  <= '0;
            pc_q                   <= DMRR_CMD_NOP;
            a2_q                   <= ADDR_RST;
            b2_q                   <= BANK_RST;
            link.cmd               <= DMRR_CMD_NOP;
            link.bank              <= BANK_RST;
            link.addr              <= ADDR_RST;
            link.rst_n             <= 1'b0;
            link.pin_mirror_select <= 1'b0;
            cmd_ready              <= 1'b0;
            init_done              <= 1'b0;
        end else begin
            link.pin_mirror_select <= mirror_req;
            link.cmd               <= DMRR_CMD_NOP;
            link.bank              <= BANK_RST;
            link.addr              <= ADDR_RST;
            cmd_ready              <= 1'b0;
            cnt_q                  <= cnt_q + CNT_W'(1);
            if (rq2_q && st_q != DMRR_S_RST) begin // RL5
                st_q       <= DMRR_S_RST;
                cnt_q      <= '0;
                link.rst_n <= 1'b0;
                init_done  <= 1'b0;
            end else begin
                case (st_q)
                    DMRR_S_RST: begin
                        // Reset low long enough for both the minimum pulse and the nop clocks
                        if (cnt_q >= CNT_W'(RST_LOW_CYC) && cnt_q >= CNT_W'(RST_NOP_CYC)) begin // RL6 RL8
                            link.rst_n <= 1'b1;
                            st_q       <= DMRR_S_HOLD;
                            cnt_q      <= '0;
                        end
                    end
                    DMRR_S_HOLD: begin
                        if (cnt_q >= CNT_W'(INIT_LOW_CYC)) begin // RL13 RL9
                            st_q <= DMRR_S_MRS;
                        end
                    end
                    DMRR_S_MRS: begin
                        link.cmd          <= DMRR_CMD_MRS; // RL11
                        link.addr         <= rev_a(dmrr_addr_t'(1) << MUX_BIT, mirror_req); // RL4
                        st_q              <= DMRR_S_WAIT;
                        cnt_q             <= '0;
                    end
                    DMRR_S_WAIT: begin
                        if (cnt_q >= CNT_W'(MRSC_CYC)) begin // RL11
                            st_q      <= DMRR_S_RUN;
                            init_done <= 1'b1;
                            cmd_ready <= 1'b1;
                        end
                    end
                    DMRR_S_RUN: begin
                        cmd_ready <= 1'b1; // RL2
                        if (take) begin
                            link.cmd  <= cmd_in;
                            link.bank <= rev_b(bank_in, mirror_req); // RL4
                            link.addr <= rev_a(addr_in, mirror_req); // RL4
                            pc_q      <= cmd_in;
                            a2_q      <= addr2_in;
                            b2_q      <= bank_in;
                            if (two) begin
                                st_q      <= DMRR_S_H2;
                                cmd_ready <= 1'b0;
                            end
                        end
                    end
                    DMRR_S_H2: begin
                        link.addr <= rev_a(a2_q, mirror_req); // RL4
                        link.bank <= rev_b({2'h0, b2_q[3:2]}, mirror_req); // RL4
                        st_q      <= (pc_q == DMRR_CMD_REFA) ? DMRR_S_GAP : DMRR_S_RUN; // RL3
                        cmd_ready <= pc_q != DMRR_CMD_REFA;
                    end
                    DMRR_S_GAP: begin
                        st_q      <= DMRR_S_RUN; // RL3
                        cmd_ready <= 1'b1;
                    end
                    default: st_q <= DMRR_S_RST;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/dmrr_mem.sv */
/*
 Memory end: command decode under multiplexed addressing, bank and all-bank refresh
 execution, pin mirroring, asynchronous reset clearing refresh counters.
 In multiplexed mode, two-part commands (reads, writes, all-bank refresh) are held for one clock while the
 second address half arrives; the command field of that clock is not decoded.
 Assumes the controller keeps reset low and spacing as contracted, drives the link from
 flip-flops on the same clk, and changes the mirror select only between commands.
 The link's active-low reset is the only reset of this end.
*/
// Contract
// [RL1] Refresh executes one edge after command edge
// [RL2] Bank refresh: next command accepted next clock
// [RL3] All-bank refresh: controller waits two cycles
// [RL4] Mirror select high swaps address/command pins
// [RL5] Reset acts asynchronously at any time
// [RL6] Controller holds reset low 100ns minimum
// [RL7] Reset disables outputs, termination, internal state
// [RL8] Controller gives 100 nop clocks before release
// [RL9] Controller reinitialises fully after reset
// [RL10] Reset clears refresh counters, data unknown
// [RL11] Mode register bit 9 enters multiplexed mode
// [RL12] Data latency from second half edge
// [RL13] Controller holds address low 10000 cycles
// [RL14] Clock after all-bank refresh is second half
`timescale 1ns/10ps
`default_nettype none
module dmrr_mem
    import dmrr_pkg::*;
(
    input  wire logic            clk,
    dmrr_link_if.mem             link,
    output logic                 mux_mode,
    output logic                 outputs_enabled,
    output logic                 on_die_termination,
    output logic                 data_unknown,
    output logic                 refresh_pulse,
    output logic [BANKS-1:0]     refresh_banks,
    output logic [REFCNT_W-1:0]  refresh_count,
    output logic                 latency_start,
    output logic                 cycle_start
);
    import dmrr_pkg::*;

    // Mirroring reverses the address and bank pin groups, not the command field; the reversal is its own inverse
    function automatic logic [ADDR_W-1:0] mirror_f(input logic [ADDR_W-1:0] v, input logic m);
        logic [ADDR_W-1:0] r;
        r = v;
        if (m) begin
            for (int i = 0; i < ADDR_W; i++) begin
                r[i] = v[ADDR_W-1-i];
            end
        end
        return r;
    endfunction

    function automatic logic [BANK_W-1:0] mirror_b(input logic [BANK_W-1:0] v, input logic m);
        logic [BANK_W-1:0] r;
        r = v;
        if (m) begin
            for (int i = 0; i < BANK_W; i++) begin
                r[i] = v[BANK_W-1-i];
            end
        end
        return r;
    endfunction

    // Reset pin is asynchronous; its release is synchronised before logic uses it
    logic       rs1_q;
    logic       rs2_q;
    wire  logic arst = ~link.rst_n; // RL5
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    wire logic       run = rs2_q;
    wire dmrr_addr_t a_in = mirror_f(link.addr, link.pin_mirror_select); // RL4
    wire dmrr_bank_t b_in = mirror_b(link.bank, link.pin_mirror_select); // RL4
    wire logic [2:0] c_in = link.cmd;

    logic       half2_q;     // Next clock carries second address half
    logic [2:0] pcmd_q;
    dmrr_bank_t pbank_q;

    wire logic is_new = run && !half2_q; // RL14
    wire logic refb   = is_new && c_in == DMRR_CMD_REFB;
    wire logic refa   = is_new && c_in == DMRR_CMD_REFA;
    wire logic rdwr   = is_new && (c_in == DMRR_CMD_RD || c_in == DMRR_CMD_WR);
    wire logic mrs    = is_new && c_in == DMRR_CMD_MRS;

    // In multiplexed mode reads, writes and all-bank refreshes wait for their second half
    wire logic park      = mux_mode && (refa || rdwr); // RL14
    wire logic flat_refa = !mux_mode && refa;
    wire logic refa_done = half2_q && pcmd_q == DMRR_CMD_REFA; // RL1 RL3
    wire logic acc_done  = half2_q && pcmd_q != DMRR_CMD_REFA;
    wire logic mux_set   = mrs && a_in[MUX_BIT]; // RL11

    // All-bank mask spans both halves: low pair from first, high pair from second.
    // A zero mask selects every bank, so the common case needs no mask at all.
    wire logic [BANK_W-1:0] mb_sel = {b_in[1:0], pbank_q[1:0]};
    wire logic [BANKS-1:0]  multi_mask;
    for (genvar g = 0; g < BANKS; g++) begin : g_mask
        assign multi_mask[g] = (BANK_W'(g) & ~mb_sel) == BANK_W'(0) || mb_sel == BANK_W'(0);
    end

    wire logic [BANKS-1:0] single_mask = BANKS'(1) << b_in;
    wire logic             pulse_d     = refb || flat_refa || refa_done; // RL1 RL2
    wire logic [BANKS-1:0] banks_d     = refb      ? single_mask :
                                         flat_refa ? {BANKS{1'b1}} :
                                         refa_done ? multi_mask : {BANKS{1'b0}};
    wire logic             latency_d   = acc_done || (rdwr && !mux_mode); // RL12
    wire logic             cycle_d     = is_new && c_in != DMRR_CMD_NOP; // RL12

    // Second-half flag; the command field on that clock is ignored
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            half2_q <= 1'b0;
        end else begin
            half2_q <= park; // RL14
        end
    end

    // First-half command and bank, held for the second-half edge
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            pcmd_q  <= DMRR_CMD_NOP;
            pbank_q <= BANK_RST;
        end else if (park) begin
            pcmd_q  <= c_in;
            pbank_q <= b_in;
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            mux_mode <= 1'b0;
        end else if (mux_set) begin
            mux_mode <= 1'b1; // RL11
        end
    end

    // Pins and termination stay off until the reset release has passed the synchroniser
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin // RL7
            outputs_enabled <= 1'b0;
        end else begin
            outputs_enabled <= run;
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin // RL7
            on_die_termination <= 1'b0;
        end else begin
            on_die_termination <= run;
        end
    end

    // Stored contents count as lost from reset until the first refresh
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin // RL10
            data_unknown <= 1'b1;
        end else if (refb || refa) begin
            data_unknown <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            refresh_pulse <= 1'b0;
        end else begin
            refresh_pulse <= pulse_d; // RL1
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            refresh_banks <= '0;
        end else begin
            refresh_banks <= banks_d;
        end
    end

    // Refresh counter clears on reset; it wraps rather than saturates
    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin // RL10
            refresh_count <= '0;
        end else if (pulse_d) begin
            refresh_count <= refresh_count + REFCNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            latency_start <= 1'b0;
        end else begin
            latency_start <= latency_d; // RL12
        end
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= cycle_d; // RL12
        end
    end
endmodule
`default_nettype wire

/* File: verification/dmrr_link_properties.sv */
/*
 Checker on the link between controller end and memory end, plus the memory end's status.
 Assumes one clock and the controller's asynchronous reset rst.
*/
`timescale 1ns/10ps
`default_nettype none
module dmrr_link_properties
    import dmrr_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [2:0]          cmd,
    input wire dmrr_bank_t          bank,
    input wire dmrr_addr_t          addr,
    input wire logic                pin_mirror_select,
    input wire logic                rst_n,
    input wire logic                mux_mode,
    input wire logic                outputs_enabled,
    input wire logic                on_die_termination,
    input wire logic                data_unknown,
    input wire logic                refresh_pulse,
    input wire logic [REFCNT_W-1:0] refresh_count,
    input wire logic                latency_start,
    input wire logic                cycle_start
);
    localparam int INIT_HOLD = INIT_LOW_CYC;
    logic [CNT_W-1:0] nop_q;
    logic [CNT_W-1:0] high_q;
    // Mode bit moves to bit 0 when the pins are mirrored
    wire logic mrs_mux = cmd == DMRR_CMD_MRS && (pin_mirror_select ? addr[0] : addr[MUX_BIT]);
    // Counters, since the reset spans are too long for a repetition
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nop_q  <= '0;
            high_q <= '0;
        end else begin
            nop_q  <= (!rst_n && cmd == DMRR_CMD_NOP) ? nop_q + 1'b1 : '0;
            high_q <= !rst_n ? '0 : (&high_q ? high_q : high_q + 1'b1);
        end
    end
    default clocking dflt @(posedge clk); endclocking
    default disable iff (rst || !rst_n);
    bank_refresh_a: assert property (cmd == DMRR_CMD_REFB && mux_mode |=> refresh_pulse)
        else $error("bank refresh late");
    all_refresh_a: assert property (cmd == DMRR_CMD_REFA && mux_mode |=> !refresh_pulse ##1 refresh_pulse)
        else $error("all-bank refresh mistimed");
    refresh_gap_a: assert property (cmd == DMRR_CMD_REFA && mux_mode |=> cmd == DMRR_CMD_NOP)
        else $error("command in all-bank second half");
    mode_spacing_a: assert property (cmd == DMRR_CMD_MRS |=> cmd == DMRR_CMD_NOP [*4])
        else $error("command too soon after mode write");
    mux_entry_a: assert property (mrs_mux |=> mux_mode)
        else $error("multiplexed mode not entered");
    data_origin_a: assert property ((cmd == DMRR_CMD_RD || cmd == DMRR_CMD_WR) && mux_mode
        |=> cycle_start && !latency_start ##1 latency_start) else $error("access origin wrong");
    reset_state_a: assert property (disable iff (rst) !rst_n
        |-> refresh_count == '0 && !outputs_enabled && !on_die_termination && data_unknown)
        else $error("state not cleared in reset");
    reset_hold_a: assert property (disable iff (rst) $fell(rst_n) |=> !rst_n)
        else $error("reset pulse too short");
    reset_nops_a: assert property (disable iff (rst) $rose(rst_n) |-> nop_q >= RST_NOP_CYC)
        else $error("too few no-ops before release");
    init_hold_a: assert property (disable iff (rst) rst_n && high_q < INIT_HOLD
        |-> cmd == DMRR_CMD_NOP && addr == '0 && bank == '0) else $error("init hold broken");
endmodule
`default_nettype wire

/* File: verification/dmrr_mux_refresh_reset_test.sv */
/*
 Testbench: controller end and memory end joined by the link; command rows, then
 back-to-back refreshes, all-bank spacing and a mid-run link reset. Assumes 10 MHz clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dmrr_mux_refresh_reset_test;
    import dmrr_pkg::*;
    typedef struct packed {
        logic [2:0]  c;
        dmrr_bank_t  b;
        logic        m;
        logic [1:0]  p;
        logic [15:0] e;
    } dmrr_row_s;
    logic                clk = 1'b0, rst = 1'b1, mirror_req = 1'b0, reset_req = 1'b0, cmd_valid = 1'b0;
    logic [2:0]          cmd_in = 3'h0;
    dmrr_bank_t          bank_in = 4'h0;
    dmrr_addr_t          addr_in = 10'h000, addr2_in = 10'h000;
    logic                cmd_ready, init_done, mux_mode, outputs_enabled, on_die_termination, data_unknown;
    logic                refresh_pulse, latency_start, cycle_start, p1;
    logic [BANKS-1:0]    refresh_banks, e1;
    logic [REFCNT_W-1:0] refresh_count;
    int                  fail_count = 0, check_count = 0, cyc = 0, n;
    dmrr_row_s rows [7] = '{'{DMRR_CMD_REFB, 4'h0, 1'b0, 2'h2, 16'h0001}, '{DMRR_CMD_REFB, 4'hA, 1'b1, 2'h2, 16'h0400},
        '{DMRR_CMD_REFB, 4'hF, 1'b0, 2'h2, 16'h8000}, '{DMRR_CMD_REFA, 4'h0, 1'b0, 2'h1, 16'hFFFF},
        '{DMRR_CMD_REFA, 4'h0, 1'b1, 2'h1, 16'hFFFF}, '{DMRR_CMD_RD, 4'h3, 1'b1, 2'h0, 16'h0000},
        '{DMRR_CMD_WR, 4'h6, 1'b0, 2'h0, 16'h0000}};
    always #50 clk = ~clk;
    dmrr_link_if link ();
    dmrr_ctrl u_dmrr_ctrl (.clk, .rst, .link, .mirror_req, .reset_req, .cmd_valid, .cmd_in, .bank_in, .addr_in,
        .addr2_in, .cmd_ready, .init_done);
    dmrr_mem u_dmrr_mem (.clk, .link, .mux_mode, .outputs_enabled, .on_die_termination, .data_unknown,
        .refresh_pulse, .refresh_banks, .refresh_count, .latency_start, .cycle_start);
    dmrr_link_properties u_dmrr_link_properties (.clk, .rst, .cmd(link.cmd), .bank(link.bank), .addr(link.addr),
        .pin_mirror_select(link.pin_mirror_select), .rst_n(link.rst_n), .mux_mode, .outputs_enabled,
        .on_die_termination, .data_unknown, .refresh_pulse, .refresh_count, .latency_start, .cycle_start);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic test_done();
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Valid stays up on return so a following call makes a back-to-back request
    task automatic issue(input logic [2:0] c, input dmrr_bank_t b, output int w);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_in = c;
        bank_in = b;
        addr_in = 10'h155;
        addr2_in = 10'h2CB;
        w = 0;
        @(posedge clk);
        while (cmd_ready !== 1'b1 && w < 20) begin
            w++;
            @(posedge clk);
        end
    endtask
    task automatic wait_init();
        n = 0;
        while (init_done !== 1'b1 && n < 11000) begin
            n++;
            @(negedge clk);
        end
        chk({init_done, mux_mode, outputs_enabled}, 3'h7);
    endtask
    task automatic release_cmd();
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        chk({link.rst_n, cmd_ready, link.cmd}, 4'h0);
        rst = 1'b0;
        wait_init();
        foreach (rows[i]) begin
            @(negedge clk);
            mirror_req = rows[i].m;
            repeat (4) @(posedge clk);
            issue(rows[i].c, rows[i].b, n);
            release_cmd();
            chk({link.cmd, link.pin_mirror_select}, {rows[i].c, rows[i].m});
            chk(link.bank, rows[i].m ? dmrr_bank_t'({<<{rows[i].b}}) : rows[i].b);
            chk(link.addr, rows[i].m ? 10'h2AA : 10'h155);
            @(posedge clk);
            #1;
            p1 = refresh_pulse;
            e1 = refresh_banks;
            if (rows[i].c != DMRR_CMD_REFB) begin
                chk(link.addr, rows[i].m ? 10'h34D : 10'h2CB);
            end
            @(posedge clk);
            #1;
            chk({p1, refresh_pulse}, rows[i].p);
            if (rows[i].p != 2'h0) begin
                chk(rows[i].p[1] ? e1 : refresh_banks, rows[i].e);
            end
        end
        issue(DMRR_CMD_REFB, 4'h3, n);
        issue(DMRR_CMD_REFB, 4'h9, n);
        chk(n, 0);
        release_cmd();
        chk(refresh_banks, 16'h0008);
        @(posedge clk);
        #1;
        chk(refresh_banks, 16'h0200);
        issue(DMRR_CMD_REFA, 4'h0, n);
        issue(DMRR_CMD_REFB, 4'h1, n);
        chk(n, 2);
        release_cmd();
        chk(refresh_count != '0, 1'b1);
        reset_req = 1'b1;
        repeat (5) @(negedge clk);
        chk({link.rst_n, outputs_enabled, on_die_termination, data_unknown}, 4'h1);
        chk(refresh_count, 0);
        reset_req = 1'b0;
        wait_init();
        chk(data_unknown, 1'b1);
        issue(DMRR_CMD_REFB, 4'h5, n);
        release_cmd();
        repeat (2) @(posedge clk);
        #1;
        chk(data_unknown, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
